// file: rtl/srgi_pkg.sv
// Purpose: shared constants for the servo reference gearing and in-position block
// Assumes: 25 MHz clk, signed 12-bit reference code (+-10 V full scale)
// Notes: register offsets are byte addresses on the plain register port
//
// Behaviour
// R1 - Gear divisor accepts 500..16384, defaults to 4096.
// R2 - Reference counts scale by 4096 over gear divisor.
// R3 - Gearing applies to pulse, analog, serial position; ignored in speed/torque.
// R4 - Analog position maps 0..10 V onto 0..90*4096/divisor degrees.
// R5 - In position when absolute error is at most the window.
// R6 - Window accepts 1..127, one feedback count each.
// R7 - In-position output high when in position, low otherwise.
// R8 - Lost-phase alarm after error at/over quarter turn for two seconds.
// R9 - Disable clears the error and holds it at zero.
// R10 - Forward reference means clockwise shaft rotation, every mode.
// R11 - Speed mode: +10 V gives 6000 rpm, linear.
// R12 - Sign of reference picks direction, magnitude from absolute value.
// R13 - Acceleration limit shapes speed steps into an s-curve.
// R14 - Speed-mode torque passes low-pass with corner 26 times constant.
// R15 - Software keeps torque filter constant at 127 in position mode.
// R16 - Torque mode: +10 V gives 10.0 A, linear.
// R17 - Host keeps pulses at most 500 kHz and at least 0.8 us wide.
// R18 - Host waits 150 ms after power-up before commanding.
// R19 - Decoder handles step/dir, A/B quadrature and CW/CCW pulse formats.
// R20 - One error accumulator feeds in-position compare and lost-phase timer.
package srgi_pkg;
  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int LOST_MS = 2000;
  localparam int LOST_CYC = LOST_MS * (CLK_HZ / 1000);
  localparam int SCURVE_DT_US = 1000;
  localparam int SCURVE_CYC = SCURVE_DT_US * (CLK_HZ / 1_000_000);
  localparam int TRQ_DT_US = 10;
  localparam int TRQ_CYC = TRQ_DT_US * (CLK_HZ / 1_000_000);
  localparam int PULSE_MIN_NS = 800;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // register byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_GEAR = 6'h04;
  localparam logic [5:0] REG_WINDOW = 6'h08;
  localparam logic [5:0] REG_ACCEL = 6'h0c;
  localparam logic [5:0] REG_TRQ = 6'h10;
  localparam logic [5:0] REG_PTP = 6'h14;
  localparam logic [5:0] REG_STATUS = 6'h18;
  localparam logic [5:0] REG_ERR = 6'h1c;
  localparam logic [5:0] REG_CMDPOS = 6'h20;
  localparam logic [5:0] REG_SPEED = 6'h24;
  localparam logic [5:0] REG_CURRENT = 6'h28;

  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FMT_LSB = 2;
  localparam int CTRL_SRC_LSB = 4;
  localparam int STAT_INPOS = 0;
  localparam int STAT_ALARM = 1;
  localparam int STAT_DIS = 2;

  // ranges and reset values
  localparam logic [14:0] GEAR_MIN = 15'h01f4;
  localparam logic [14:0] GEAR_MAX = 15'h4000;
  localparam logic [14:0] GEAR_RST = 15'h1000;
  localparam logic [17:0] GEAR_NUM = 18'h01000;
  localparam logic [6:0] WIN_MIN = 7'h01;
  localparam logic [6:0] WIN_MAX = 7'h7f;
  localparam logic [6:0] WIN_RST = 7'h0a;
  localparam logic [6:0] ACCEL_RST = 7'h00;
  localparam logic [6:0] TRQ_RST = 7'h7f;
  localparam logic [31:0] QUARTER_REV = 32'h00001000;

  // scaling
  localparam logic signed [25:0] SPD_FULL_RPM = 26'sh0001770;
  localparam logic signed [25:0] CUR_FULL_MA = 26'sh0002710;
  localparam int REF_SHIFT = 11;
  localparam logic [9:0] ALPHA_K = 10'h3ac;
  localparam logic [4:0] TRQ_ALPHA_K = 5'h11;

  typedef enum logic [1:0] {
    SRGI_MODE_POS = 2'b00,
    SRGI_MODE_SPEED = 2'b01,
    SRGI_MODE_TORQUE = 2'b10
  } srgi_mode_t;

  typedef enum logic [1:0] {
    SRGI_FMT_STEPDIR = 2'b00,
    SRGI_FMT_QUAD = 2'b01,
    SRGI_FMT_CWCCW = 2'b10
  } srgi_fmt_t;

  typedef enum logic [1:0] {
    SRGI_SRC_PULSE = 2'b00,
    SRGI_SRC_ANALOG = 2'b01,
    SRGI_SRC_SERIAL = 2'b10
  } srgi_src_t;
endpackage

// file: rtl/srgi_pulse_dec.sv
// Purpose: reference pulse decoder, three formats
// Assumes: pins asynchronous to clk, pulses at least 0.8 us wide
// Notes: outputs one-cycle count pulses, up means forward (clockwise)
`timescale 1ns/1ps
`default_nettype none
module srgi_pulse_dec
  import srgi_pkg::*;
(
  input wire logic clk, // control clock
  input wire logic srst, // sync reset
  input wire logic pin_a, // step / A / clockwise_pulse_input
  input wire logic pin_b, // dir / B / counterclockwise_pulse_input
  input wire logic [1:0] fmt, // pulse format
  output logic cnt_up, // forward count pulse
  output logic cnt_dn // reverse count pulse
);
  // ----------
  // synchronisers
  // ----------
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= 2'b00;
      sync_q <= 2'b00;
      prev_q <= 2'b00;
    end else begin
      meta_q <= {pin_b, pin_a};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // ----------
  // decode
  // ----------
  wire logic a_rise = sync_q[0] & ~prev_q[0];
  wire logic b_rise = sync_q[1] & ~prev_q[1];
  wire logic a_chg = sync_q[0] ^ prev_q[0];
  wire logic b_chg = sync_q[1] ^ prev_q[1];
  // x4 quadrature: A leading B is forward
  wire logic q_up = (a_chg & (sync_q[0] ^ sync_q[1])) | (b_chg & ~(sync_q[0] ^ sync_q[1]));
  wire logic q_dn = (a_chg & ~(sync_q[0] ^ sync_q[1])) | (b_chg & (sync_q[0] ^ sync_q[1]));
  // both channels moving at once is an illegal quadrature jump, dropped
  wire logic q_ok = ~(a_chg & b_chg);

  always_comb begin
    cnt_up = 1'b0;
    cnt_dn = 1'b0;
    case (fmt)
      // R19 step with direction, dir low forward
      SRGI_FMT_STEPDIR: begin
        cnt_up = a_rise & ~sync_q[1];
        cnt_dn = a_rise & sync_q[1];
      end
      // R19 quadrature both edges
      SRGI_FMT_QUAD: begin
        cnt_up = q_up & q_ok;
        cnt_dn = q_dn & q_ok;
      end
      // R19 separate pulse trains
      SRGI_FMT_CWCCW: begin
        cnt_up = a_rise & ~b_rise;
        cnt_dn = b_rise & ~a_rise;
      end
      default: begin
        cnt_up = 1'b0;
        cnt_dn = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: rtl/srgi_top.sv
// Purpose: reference gearing, in-position, lost phase, speed/torque conditioning
// Assumes: enc_pos and ref_code come from logic on clk; pins are asynchronous
// Notes: host must keep pulse timing and the power-up wait, nothing here checks it
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module srgi_top
  import srgi_pkg::*;
#(
  parameter int LOST_CYCLES = LOST_CYC, // lost-phase persistence
  parameter int SCURVE_CYCLES = SCURVE_CYC // s-curve update period
) (
  input wire logic clk, // 25 MHz control clock
  input wire logic srst, // sync reset, active high
  input wire logic [5:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic pin_a, // step / A / clockwise pulse pin
  input wire logic pin_b, // dir / B / counterclockwise pulse pin
  input wire logic drive_disable_input, // disable pin, high disables
  input wire logic signed [11:0] ref_code, // digitised analog reference
  input wire logic signed [31:0] enc_pos, // measured position, counts
  input wire logic signed [15:0] torque_req, // velocity loop torque demand
  output logic in_position_output, // high while in position
  output logic lost_phase_alarm, // sticky alarm
  output logic signed [31:0] cmd_pos, // geared commanded position
  output logic signed [15:0] speed_cmd, // shaped speed, rpm
  output logic speed_dir_cw, // speed direction, high clockwise
  output logic [15:0] speed_mag, // speed magnitude, rpm
  output logic signed [15:0] current_cmd, // torque mode current, mA
  output logic signed [15:0] torque_cmd // torque command, low-pass filtered in speed mode only
);
  // ----------
  // registers
  // ----------
  logic [1:0] mode_q;
  logic [1:0] fmt_q;
  logic [1:0] src_q;
  logic [14:0] gear_q;
  logic [6:0] win_q;
  logic [6:0] accel_q;
  logic [6:0] trqk_q;
  logic signed [31:0] ptp_q;
  logic alarm_q;
  logic [31:0] rdata_q;

  wire logic wr_ctrl = wr & (addr == REG_CTRL);
  wire logic wr_gear = wr & (addr == REG_GEAR);
  wire logic wr_win = wr & (addr == REG_WINDOW);
  wire logic wr_accel = wr & (addr == REG_ACCEL);
  wire logic wr_trq = wr & (addr == REG_TRQ);
  wire logic wr_ptp = wr & (addr == REG_PTP);
  wire logic wr_stat = wr & (addr == REG_STATUS);

  // R1 out-of-range divisor clamped
  wire logic [14:0] gear_w = wdata[14:0];
  wire logic gear_big = (wdata[31:15] != 17'h0) | (gear_w > GEAR_MAX);
  wire logic [14:0] gear_d = gear_big ? GEAR_MAX : (gear_w < GEAR_MIN) ? GEAR_MIN : gear_w;
  // R6 window clamped to 1..127
  wire logic [6:0] win_d = (wdata[31:7] != 25'h0) ? WIN_MAX :
                           (wdata[6:0] < WIN_MIN) ? WIN_MIN : wdata[6:0];

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= SRGI_MODE_POS;
      fmt_q <= SRGI_FMT_STEPDIR;
      src_q <= SRGI_SRC_PULSE;
      // R1 default divisor
      gear_q <= GEAR_RST;
      win_q <= WIN_RST;
      accel_q <= ACCEL_RST;
      trqk_q <= TRQ_RST;
      ptp_q <= 32'sh0;
    end else begin
      if (wr_ctrl) begin
        mode_q <= wdata[CTRL_MODE_LSB +: 2];
        fmt_q <= wdata[CTRL_FMT_LSB +: 2];
        src_q <= wdata[CTRL_SRC_LSB +: 2];
      end
      if (wr_gear) gear_q <= gear_d;
      if (wr_win) win_q <= win_d;
      if (wr_accel) accel_q <= wdata[6:0];
      if (wr_trq) trqk_q <= wdata[6:0];
      if (wr_ptp) ptp_q <= wdata;
    end
  end

  // ----------
  // disable pin and pulse decoder
  // ----------
  logic dis_meta_q;
  logic dis_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      dis_meta_q <= 1'b1;
      dis_q <= 1'b1;
    end else begin
      dis_meta_q <= drive_disable_input;
      dis_q <= dis_meta_q;
    end
  end

  logic dec_up;
  logic dec_dn;
  srgi_pulse_dec u_dec (
    .clk(clk),
    .srst(srst),
    .pin_a(pin_a),
    .pin_b(pin_b),
    .fmt(fmt_q),
    .cnt_up(dec_up),
    .cnt_dn(dec_dn)
  );

  // ----------
  // reference source and gearing
  // ----------
  // R3 position loop only runs in position mode
  wire logic pos_run = (mode_q == SRGI_MODE_POS) & ~dis_q;
  logic signed [31:0] raw_q;
  logic signed [17:0] res_q;
  logic signed [31:0] cmd_q;

  wire logic signed [17:0] div_s = $signed({3'b000, gear_q});
  wire logic drain_up = res_q >= div_s;
  wire logic drain_dn = res_q <= -div_s;
  wire logic gear_busy = drain_up | drain_dn;
  // R4 0..10 V is codes 0..2047, doubled gives a quarter turn before gearing
  wire logic signed [31:0] ana_tgt = ref_code[11] ? 32'sh0 : $signed({19'h0, ref_code, 1'b0});
  wire logic signed [31:0] int_tgt = (src_q == SRGI_SRC_ANALOG) ? ana_tgt : ptp_q;
  wire logic use_pulse = src_q == SRGI_SRC_PULSE;
  // internal targets step one count at a time while the gear is idle
  wire logic int_up = ~use_pulse & ~gear_busy & (raw_q < int_tgt);
  wire logic int_dn = ~use_pulse & ~gear_busy & (raw_q > int_tgt);
  // R10 up counts are forward, clockwise
  wire logic raw_up = pos_run & (use_pulse ? dec_up : int_up);
  wire logic raw_dn = pos_run & (use_pulse ? dec_dn : int_dn);
  // R2 each reference count adds 4096, each divisor drained is one count
  wire logic signed [17:0] res_add = raw_up ? $signed(GEAR_NUM) :
                                     raw_dn ? -$signed(GEAR_NUM) : 18'sh0;
  wire logic signed [17:0] res_sub = drain_up ? div_s : drain_dn ? -div_s : 18'sh0;
  wire logic signed [1:0] cmd_step = drain_up ? 2'sb01 : drain_dn ? 2'sb11 : 2'sb00;

  always_ff @(posedge clk) begin
    if (srst) begin
      raw_q <= 32'sh0;
      res_q <= 18'sh0;
      cmd_q <= 32'sh0;
    end else if (!pos_run) begin
      res_q <= 18'sh0;
    end else begin
      // R3 geared path shared by every position source
      if (raw_up) raw_q <= raw_q + 32'sh1;
      else if (raw_dn) raw_q <= raw_q - 32'sh1;
      res_q <= res_q + res_add - res_sub;
      cmd_q <= cmd_q + 32'(cmd_step);
    end
  end
  assign cmd_pos = cmd_q;

  // ----------
  // position error, in position, lost phase
  // ----------
  logic signed [31:0] enc_prev_q;
  logic signed [31:0] err_q;
  logic [31:0] lost_cnt_q;
  logic inpos_q;
  wire logic signed [31:0] enc_delta = enc_pos - enc_prev_q;
  wire logic [31:0] err_abs = err_q[31] ? 32'(-err_q) : 32'(err_q);
  wire logic err_big = err_abs >= QUARTER_REV;

  always_ff @(posedge clk) begin
    if (srst) begin
      enc_prev_q <= 32'sh0;
      err_q <= 32'sh0;
    end else begin
      enc_prev_q <= enc_pos;
      // R9 disabled drive holds error at zero
      if (!pos_run) err_q <= 32'sh0;
      // R20 single running difference of command and feedback
      else err_q <= err_q + 32'(cmd_step) - enc_delta;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      inpos_q <= 1'b0;
      lost_cnt_q <= 32'h0;
      alarm_q <= 1'b0;
    end else begin
      // R5 window compare on absolute error
      // R7 high while in position
      inpos_q <= (err_abs <= {25'h0, win_q});
      // R8 continuous quarter-turn error for the full period
      if (!err_big) lost_cnt_q <= 32'h0;
      else if (lost_cnt_q < LOST_CYCLES[31:0]) lost_cnt_q <= lost_cnt_q + 32'h1;
      // set wins over a software clear in the same cycle
      if (err_big && lost_cnt_q == LOST_CYCLES[31:0] - 32'h1) alarm_q <= 1'b1;
      else if (wr_stat && wdata[STAT_ALARM]) alarm_q <= 1'b0;
    end
  end
  assign in_position_output = inpos_q;
  assign lost_phase_alarm = alarm_q;

  // ----------
  // rate enables
  // ----------
  logic [31:0] sc_div_q;
  logic [15:0] tq_div_q;
  wire logic sc_tick = sc_div_q == SCURVE_CYCLES[31:0] - 32'h1;
  wire logic tq_tick = tq_div_q == TRQ_CYC[15:0] - 16'h1;
  always_ff @(posedge clk) begin
    if (srst) begin
      sc_div_q <= 32'h0;
      tq_div_q <= 16'h0;
    end else begin
      sc_div_q <= sc_tick ? 32'h0 : sc_div_q + 32'h1;
      tq_div_q <= tq_tick ? 16'h0 : tq_div_q + 16'h1;
    end
  end

  // ----------
  // speed mode, s-curve shaping
  // ----------
  // R11 full-scale code is 6000 rpm
  wire logic signed [25:0] spd_prod = 26'(ref_code) * SPD_FULL_RPM;
  wire logic signed [15:0] spd_tgt = 16'(spd_prod >>> REF_SHIFT);
  // two cascaded first-order stages give the s-shape; tau tracks 1/accel^2
  wire logic [13:0] acc_sq = 14'(accel_q * accel_q);
  wire logic [23:0] alpha_full = 24'(acc_sq * ALPHA_K);
  wire logic signed [16:0] alpha_s = $signed({1'b0, alpha_full[23:8]});
  logic signed [23:0] s1_q;
  logic signed [23:0] s2_q;
  wire logic signed [23:0] spd_x = {spd_tgt, 8'h00};
  wire logic signed [24:0] d1 = 25'(spd_x) - 25'(s1_q);
  wire logic signed [24:0] d2 = 25'(s1_q) - 25'(s2_q);
  wire logic signed [41:0] p1 = 42'(d1) * 42'(alpha_s);
  wire logic signed [41:0] p2 = 42'(d2) * 42'(alpha_s);
  wire logic spd_run = (mode_q == SRGI_MODE_SPEED) & ~dis_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= 24'sh0;
      s2_q <= 24'sh0;
    end else if (!spd_run) begin
      s1_q <= 24'sh0;
      s2_q <= 24'sh0;
    end else if (accel_q == 7'h00) begin
      s1_q <= spd_x;
      s2_q <= spd_x;
    end else if (sc_tick) begin
      // R13 acceleration-limited s-curve
      s1_q <= s1_q + 24'(p1 >>> 16);
      s2_q <= s2_q + 24'(p2 >>> 16);
    end
  end

  logic signed [15:0] spd_q;
  logic dir_q;
  logic [15:0] mag_q;
  wire logic signed [15:0] spd_now = s2_q[23:8];
  always_ff @(posedge clk) begin
    if (srst) begin
      spd_q <= 16'sh0;
      dir_q <= 1'b1;
      mag_q <= 16'h0;
    end else begin
      spd_q <= spd_now;
      // R12 sign gives direction, magnitude is absolute
      // R10 positive is clockwise
      dir_q <= ~spd_now[15];
      mag_q <= spd_now[15] ? 16'(-spd_now) : 16'(spd_now);
    end
  end
  assign speed_cmd = spd_q;
  assign speed_dir_cw = dir_q;
  assign speed_mag = mag_q;

  // ----------
  // torque filter and torque mode current
  // ----------
  // R15 filter bypassed outside speed mode
  wire logic [11:0] ta_full = 12'(trqk_q * TRQ_ALPHA_K);
  wire logic signed [12:0] ta_s = $signed({1'b0, ta_full});
  logic signed [23:0] tf_q;
  wire logic signed [23:0] trq_x = {torque_req, 8'h00};
  wire logic signed [24:0] td = 25'(trq_x) - 25'(tf_q);
  wire logic signed [37:0] tp = 38'(td) * 38'(ta_s);
  always_ff @(posedge clk) begin
    if (srst) tf_q <= 24'sh0;
    else if (mode_q != SRGI_MODE_SPEED) tf_q <= trq_x;
    // R14 corner of 26 per unit of the constant, 10 us step
    else if (tq_tick) tf_q <= tf_q + 24'(tp >>> 16);
  end
  assign torque_cmd = tf_q[23:8];

  // R16 full-scale code is 10000 mA
  wire logic signed [25:0] cur_prod = 26'(ref_code) * CUR_FULL_MA;
  logic signed [15:0] cur_q;
  always_ff @(posedge clk) begin
    if (srst) cur_q <= 16'sh0;
    else if ((mode_q == SRGI_MODE_TORQUE) && !dis_q) cur_q <= 16'(cur_prod >>> REF_SHIFT);
    else cur_q <= 16'sh0;
  end
  assign current_cmd = cur_q;

  // ----------
  // read port
  // ----------
  wire logic [31:0] ctrl_rd = {26'h0, src_q, fmt_q, mode_q};
  wire logic [31:0] stat_rd = {29'h0, dis_q, alarm_q, inpos_q};
  logic [31:0] rd_mux;
  always_comb begin
    case (addr)
      REG_CTRL: rd_mux = ctrl_rd;
      REG_GEAR: rd_mux = {17'h0, gear_q};
      REG_WINDOW: rd_mux = {25'h0, win_q};
      REG_ACCEL: rd_mux = {25'h0, accel_q};
      REG_TRQ: rd_mux = {25'h0, trqk_q};
      REG_PTP: rd_mux = ptp_q;
      REG_STATUS: rd_mux = stat_rd;
      REG_ERR: rd_mux = err_q;
      REG_CMDPOS: rd_mux = cmd_q;
      REG_SPEED: rd_mux = 32'(spd_q);
      REG_CURRENT: rd_mux = 32'(cur_q);
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) rdata_q <= 32'h0;
    else rdata_q <= rd ? rd_mux : 32'h0;
  end
  assign rdata = rdata_q;
endmodule
`default_nettype wire

// file: tb/srgi_assertions.sv
// Purpose: port checks for srgi_top
// Assumes: reset held for at least two edges
// Notes: the error value is judged only through its effects
`timescale 1ns/1ps
`default_nettype none
module srgi_assertions
  import srgi_pkg::*;
#(
  parameter int LOST_CYCLES = LOST_CYC // alarm delay
) (
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic [5:0] addr, // address
  input wire logic [31:0] wdata, // data
  input wire logic wr, // write
  input wire logic rd, // read
  input wire logic [31:0] rdata, // read data
  input wire logic drive_disable_input, // disable
  input wire logic signed [11:0] ref_code, // reference
  input wire logic in_position_output, // in position
  input wire logic lost_phase_alarm, // alarm
  input wire logic signed [31:0] cmd_pos, // position
  input wire logic signed [15:0] speed_cmd, // speed
  input wire logic speed_dir_cw, // direction
  input wire logic [15:0] speed_mag, // magnitude
  input wire logic signed [15:0] current_cmd // current
);
  // ----------
  // helpers
  // ----------
  logic [15:0] low_q;
  wire logic clr = wr && addr == REG_STATUS && wdata[STAT_ALARM];
  // saturating run of out-of-window cycles
  always_ff @(posedge clk) begin
    low_q <= (srst || in_position_output) ? 16'h0 : low_q + {15'h0, ~&low_q};
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_rd_idle; !$past(rd) |-> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_step; (cmd_pos - $past(cmd_pos)) inside {-1, 0, 1}; endproperty
  a_step: assert property (p_step) else $error("cmd_pos jumped");
  property p_dis; drive_disable_input [*6] |-> in_position_output; endproperty
  a_dis: assert property (p_dis) else $error("error not cleared");
  property p_dir; speed_dir_cw == (speed_cmd >= 0); endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_mag; speed_mag == (speed_cmd < 0 ? -speed_cmd : speed_cmd); endproperty
  a_mag: assert property (p_mag) else $error("magnitude wrong");
  property p_cur; current_cmd != 0 |-> current_cmd[15] == $past(ref_code[11]); endproperty
  a_cur: assert property (p_cur) else $error("current sign wrong");
  property p_hold; lost_phase_alarm && !clr |=> lost_phase_alarm; endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped");
  property p_set; $rose(lost_phase_alarm) |-> low_q >= LOST_CYCLES - 3; endproperty
  a_set: assert property (p_set) else $error("alarm too early");
  cover property ($rose(lost_phase_alarm));
  cover property ($fell(in_position_output));
  cover property (current_cmd < 0);
endmodule
bind srgi_top srgi_assertions #(.LOST_CYCLES(LOST_CYCLES)) srgi_assertions_i (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .drive_disable_input(drive_disable_input), .ref_code(ref_code),
  .in_position_output(in_position_output), .lost_phase_alarm(lost_phase_alarm),
  .cmd_pos(cmd_pos), .speed_cmd(speed_cmd), .speed_dir_cw(speed_dir_cw),
  .speed_mag(speed_mag), .current_cmd(current_cmd)
);
`default_nettype wire

// file: tb/srgi_host_model.sv
// Purpose: host controller driving reference pulses
// Assumes: pins idle low between bursts
// Notes: pins change at most once per half period, never faster
`timescale 1ns/1ps
`default_nettype none
module srgi_host_model
  import srgi_pkg::*;
#(
  parameter int WAIT_CYCLES = 100, // power-up quiet time, shortened
  parameter int HALF_CYCLES = 25 // half of a 500 kHz period
) (
  input wire logic clk, // clock
  output logic pin_a, // step / A / cw pin
  output logic pin_b // dir / B / ccw pin
);
  logic ready;
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    ready = 1'b0;
    repeat (WAIT_CYCLES) @(posedge clk);
    ready = 1'b1;
  end
  // width and rate from half period
  task automatic quarter(input logic a, input logic b);
    @(posedge clk);
    pin_a <= a;
    pin_b <= b;
    repeat (HALF_CYCLES - 1) @(posedge clk);
  endtask
  task automatic burst(input logic [1:0] fmt, input logic fwd, input int n);
    while (!ready) @(posedge clk);
    if (fmt == SRGI_FMT_STEPDIR) quarter(1'b0, !fwd);
    for (int i = 0; i < n; i++) begin
      if (fmt == SRGI_FMT_STEPDIR) begin
        quarter(1'b1, !fwd);
        quarter(1'b0, !fwd);
      end else if (fmt == SRGI_FMT_QUAD) begin
        quarter(fwd, !fwd);
        quarter(1'b1, 1'b1);
        quarter(!fwd, fwd);
        quarter(1'b0, 1'b0);
      end else begin
        quarter(fwd, !fwd);
        quarter(1'b0, 1'b0);
      end
    end
    quarter(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench for srgi_top
// Assumes: shortened alarm and s-curve periods
// Notes: encoder moves only in the alarm scenario
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srgi_pkg::*;
  logic clk, srst, wr, rd, dis, pin_a, pin_b, inpos, alarm, dir_cw;
  logic [5:0] addr;
  logic [31:0] wdata, rdata;
  logic signed [11:0] ref_code;
  logic signed [31:0] enc_pos, cmd_pos;
  logic signed [15:0] torque_req, speed_cmd, current_cmd, torque_cmd;
  logic [15:0] speed_mag;
  int errors = 0, compares = 0, cycles = 0;
  srgi_host_model srgi_host_model_i (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));
  srgi_top #(.LOST_CYCLES(50), .SCURVE_CYCLES(10)) srgi_top_i (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_a(pin_a), .pin_b(pin_b), .drive_disable_input(dis), .ref_code(ref_code),
    .enc_pos(enc_pos), .torque_req(torque_req), .in_position_output(inpos),
    .lost_phase_alarm(alarm), .cmd_pos(cmd_pos), .speed_cmd(speed_cmd),
    .speed_dir_cw(dir_cw), .speed_mag(speed_mag), .current_cmd(current_cmd),
    .torque_cmd(torque_cmd));
  // ----------
  // helpers
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_reset();
    rchk(REG_GEAR, 32'h1000);
    rchk(REG_WINDOW, 32'ha);
    rchk(REG_TRQ, 32'h7f);
    rchk(REG_ACCEL, 32'h0);
    wreg(6'h3c, 32'h1);
    rchk(6'h3c, 32'h0);
  endtask
  task automatic t_clamp();
    wreg(REG_GEAR, 32'h64);
    rchk(REG_GEAR, 32'h1f4);
    wreg(REG_GEAR, 32'h4001);
    rchk(REG_GEAR, 32'h4000);
    wreg(REG_WINDOW, 32'h0);
    rchk(REG_WINDOW, 32'h1);
    wreg(REG_WINDOW, 32'h80);
    rchk(REG_WINDOW, 32'h7f);
    wreg(REG_WINDOW, 32'ha);
    wreg(REG_GEAR, 32'h1000);
  endtask
  task automatic t_pulse();
    int n;
    @(posedge clk) dis <= 1'b0;
    for (int f = 0; f < 3; f++) begin
      n = (f == 1) ? 12 : 3;
      wreg(REG_CTRL, f << 2);
      srgi_host_model_i.burst(f[1:0], 1'b1, 3);
      tick(20);
      check(cmd_pos, n);
      check(inpos, n <= 10);
      rchk(REG_ERR, n);
      srgi_host_model_i.burst(f[1:0], 1'b0, 3);
      tick(20);
      check(cmd_pos, 32'h0);
      check(inpos, 1'b1);
    end
    wreg(REG_CTRL, 32'h0);
  endtask
  task automatic t_gear();
    wreg(REG_GEAR, 32'h1f4);
    srgi_host_model_i.burst(2'h0, 1'b1, 4);
    tick(20);
    check(cmd_pos, 32'h20);
    check(inpos, 1'b0);
    @(posedge clk) dis <= 1'b1;
    tick(8);
    rchk(REG_ERR, 32'h0);
    rchk(REG_STATUS, 32'h5);
    srgi_host_model_i.burst(2'h0, 1'b1, 2);
    tick(20);
    check(cmd_pos, 32'h20);
    rchk(REG_ERR, 32'h0);
    @(posedge clk) dis <= 1'b0;
    wreg(REG_GEAR, 32'h1000);
    tick(6);
    rchk(REG_ERR, 32'h0);
  endtask
  task automatic t_alarm();
    @(posedge clk) enc_pos <= enc_pos - 32'sh1388;
    tick(30);
    check(alarm, 1'b0);
    tick(40);
    check(alarm, 1'b1);
    @(posedge clk) enc_pos <= 32'sh0;
    tick(5);
    check(alarm, 1'b1);
    check(inpos, 1'b1);
    wreg(REG_STATUS, 32'h2);
    rchk(REG_STATUS, 32'h1);
  endtask
  task automatic t_speed();
    wreg(REG_CTRL, 32'h1);
    ref_code <= 12'sh400;
    srgi_host_model_i.burst(2'h0, 1'b1, 2);
    tick(40);
    check(cmd_pos, 32'h20);
    check(speed_cmd, 32'hbb8);
    check({dir_cw, speed_mag}, 17'h10bb8);
    @(posedge clk) ref_code <= 12'shd9a;
    tick(40);
    check(speed_cmd, 32'hfffff8f9);
    check({dir_cw, speed_mag}, 17'h00707);
    wreg(REG_ACCEL, 32'h40);
    ref_code <= 12'sh400;
    tick(20);
    check(speed_cmd == 16'hbb8, 1'b0);
    @(posedge clk) torque_req <= 16'sh3e80;
    tick(300);
    check(torque_cmd > 0 && torque_cmd < 16'sh3e80, 1'b1);
    wreg(REG_ACCEL, 32'h0);
  endtask
  task automatic t_torque();
    logic [11:0] code [4] = '{12'h7ff, 12'h400, 12'hd9a, 12'h0};
    logic [31:0] amps [4] = '{32'h270b, 32'h1388, 32'hfffff449, 32'h0};
    wreg(REG_CTRL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) ref_code <= code[i];
      tick(4);
      check(current_cmd, amps[i]);
    end
    wreg(REG_TRQ, 32'h7f);
    wreg(REG_CTRL, 32'h0);
  endtask
  task automatic t_ref();
    wreg(REG_CTRL, 32'h10);
    ref_code <= 12'sh20;
    tick(150);
    check(cmd_pos, 32'h5c);
    wreg(REG_PTP, 32'h4);
    wreg(REG_CTRL, 32'h20);
    tick(150);
    check(cmd_pos, 32'h20);
  endtask
  // ----------
  // main
  // ----------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 6'h0;
    wdata = 32'h0;
    dis = 1'b1;
    ref_code = 12'sh0;
    enc_pos = 32'sh0;
    torque_req = 16'sh0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_clamp();
    t_pulse();
    t_gear();
    t_alarm();
    t_speed();
    t_torque();
    t_ref();
    summarize();
  end
endmodule
`default_nettype wire
